// file: rtl/mcc_pkg.sv
// shared constants, register map and types of the master clock controller
package mcc_pkg;
	localparam int CLK_PERIOD_NS   = 20;
	localparam int FCM_TIMEOUT_NS  = 2000;
	// failure is declared no sooner than the timeout, so round up
	localparam int FCM_TIMEOUT_CYC = (FCM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FCM_CNT_W       = $clog2(FCM_TIMEOUT_CYC + 1);

	localparam int NUM_SRC   = 4;
	localparam int SRC_W     = 2;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 8;
	localparam int NUM_PERIPH = 10;

	localparam logic [SRC_W-1:0] SRC_FAST_RC = 2'h0;
	localparam logic [SRC_W-1:0] SRC_SLOW_RC = 2'h1;
	localparam logic [SRC_W-1:0] SRC_HS_XTAL = 2'h2;
	localparam logic [SRC_W-1:0] SRC_HS_USER = 2'h3;

	localparam logic [ADDR_W-1:0] REG_SRC_REQ  = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SW_STAT  = 8'h01;
	localparam logic [ADDR_W-1:0] REG_CLK_DIV  = 8'h02;
	localparam logic [ADDR_W-1:0] REG_GATE     = 8'h03;
	localparam logic [ADDR_W-1:0] REG_PCKEN1   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PCKEN2   = 8'h05;
	localparam logic [ADDR_W-1:0] REG_FCM      = 8'h06;
	localparam logic [ADDR_W-1:0] REG_CKO      = 8'h07;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h09;

	localparam int CPU_DIV_LSB  = 0;
	localparam int CPU_DIV_W    = 3;
	localparam int FAST_DIV_LSB = 3;
	localparam int FAST_DIV_W   = 2;
	localparam int CLK_DIV_W    = 5;
	localparam logic [FAST_DIV_W-1:0] FAST_DIV_8 = 2'h3;
	localparam logic [CLK_DIV_W-1:0]  RST_CLK_DIV = 5'h18;

	localparam int GATE_CORE = 0;
	localparam int GATE_MEM  = 1;
	localparam logic [1:0] RST_GATE = 2'h3;
	localparam logic [DATA_W-1:0] RST_PCKEN1  = 8'hFF;
	localparam logic [DATA_W-1:0] PCKEN2_MASK = 8'h0C;
	localparam logic [DATA_W-1:0] RST_PCKEN2  = 8'h0C;
	localparam int PCKEN2_ADC = 3;
	localparam int PCKEN2_WKU = 2;

	localparam int CKO_EN  = 0;
	localparam int CKO_CFG_W = 4;
	localparam logic [2:0] CKO_SEL_MASTER = 3'h4;
	localparam logic [2:0] CKO_SEL_CPU    = 3'h5;

	localparam int IRQ_W       = 2;
	localparam int IRQ_FCM     = 0;
	localparam int IRQ_SW_DONE = 1;

	typedef enum {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} mcc_sw_state_t;
endpackage

// file: rtl/mcc_sw_if.sv
// signals between the controller and its glitch-free source switch
interface mcc_sw_if;
	logic [mcc_pkg::NUM_SRC-1:0] srcTick;
	logic [mcc_pkg::NUM_SRC-1:0] srcReady;
	logic                        req;
	logic [mcc_pkg::SRC_W-1:0]   reqSrc;
	logic                        forceFast;
	logic                        busy;
	logic [mcc_pkg::SRC_W-1:0]   curSrc;
	logic                        masterTick;
	logic                        done;
	modport ctrl (output srcTick, srcReady, req, reqSrc, forceFast,
		input busy, curSrc, masterTick, done);
	modport sw (input srcTick, srcReady, req, reqSrc, forceFast,
		output busy, curSrc, masterTick, done);
endinterface

// file: rtl/mcc_divider.sv
// power-of-two tick divider, ratio 2**divSel
module mcc_divider #(
	parameter int DIV_W = 3
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             tickIn,
	input  wire logic [DIV_W-1:0] divSel,
	output logic                  tickOut
);
	localparam int CNT_W = (1 << DIV_W) - 1;

	if (DIV_W < 1 || DIV_W > 4) begin : g_bad_width
		$error("mcc_divider: DIV_W must be 1 to 4");
	end

	logic [CNT_W-1:0] cnt_ff;
	logic             tickOut_ff;
	wire  [CNT_W-1:0] mask = CNT_W'((32'd1 << divSel) - 32'd1);
	wire              wrap = (cnt_ff & mask) == mask;

	// a ratio change mid-count may shorten one divided period
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff     <= '0;
			tickOut_ff <= 1'b0;
		end else begin
			if (tickIn)
				cnt_ff <= wrap ? '0 : CNT_W'(cnt_ff + 1'b1);
			tickOut_ff <= tickIn && wrap;
		end
	end

	assign tickOut = tickOut_ff;
endmodule

// file: rtl/mcc_clk_switch.sv
// glitch-free master source switch working on source tick enables
module mcc_clk_switch (
	input wire logic ref_clk,
	input wire logic rst_n,
	mcc_sw_if.sw     sw
);
	mcc_pkg::mcc_sw_state_t          state_ff, nxt_state;
	logic [mcc_pkg::SRC_W-1:0]       curSrc_ff, nxt_curSrc, tgtSrc_ff, nxt_tgtSrc;
	logic                            masterTick_ff;
	logic                            done_ff;

	wire oldTick  = sw.srcTick[curSrc_ff];
	wire newTick  = sw.srcTick[tgtSrc_ff];
	wire tgtReady = sw.srcReady[tgtSrc_ff];
	// muted from the last old edge until a full new period has run
	wire passOld  = (state_ff != mcc_pkg::SW_WAIT_NEW) && oldTick;
	wire commit   = (state_ff == mcc_pkg::SW_WAIT_NEW) && newTick;

	always_comb begin
		nxt_state  = state_ff;
		nxt_curSrc = curSrc_ff;
		nxt_tgtSrc = tgtSrc_ff;
		case (state_ff)
			mcc_pkg::SW_IDLE: begin
				if (sw.req && sw.reqSrc != curSrc_ff) begin
					nxt_tgtSrc = sw.reqSrc;
					nxt_state  = mcc_pkg::SW_WAIT_OLD;
				end
			end
			mcc_pkg::SW_WAIT_OLD: begin
				if (sw.req) begin
					nxt_tgtSrc = sw.reqSrc;
					if (sw.reqSrc == curSrc_ff)
						nxt_state = mcc_pkg::SW_IDLE;
				end else if (tgtReady && oldTick) begin
					nxt_state = mcc_pkg::SW_WAIT_NEW;
				end
			end
			mcc_pkg::SW_WAIT_NEW: begin
				if (newTick) begin
					nxt_curSrc = tgtSrc_ff;
					nxt_state  = mcc_pkg::SW_IDLE;
				end
			end
			default: nxt_state = mcc_pkg::SW_IDLE;
		endcase
		// a dead external source gives no last edge to wait for
		if (sw.forceFast) begin
			nxt_tgtSrc = mcc_pkg::SRC_FAST_RC;
			nxt_state  = mcc_pkg::SW_WAIT_NEW;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff      <= mcc_pkg::SW_IDLE;
			curSrc_ff     <= mcc_pkg::SRC_FAST_RC;
			tgtSrc_ff     <= mcc_pkg::SRC_FAST_RC;
			masterTick_ff <= 1'b0;
			done_ff       <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			curSrc_ff     <= nxt_curSrc;
			tgtSrc_ff     <= nxt_tgtSrc;
			masterTick_ff <= passOld;
			done_ff       <= commit;
		end
	end

	assign sw.busy       = state_ff != mcc_pkg::SW_IDLE;
	assign sw.curSrc     = curSrc_ff;
	assign sw.masterTick = masterTick_ff;
	assign sw.done       = done_ff;

	property p_hold_until_ready;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == mcc_pkg::SW_WAIT_OLD && !tgtReady && !sw.forceFast && !sw.req)
			|=> state_ff == mcc_pkg::SW_WAIT_OLD && $stable(curSrc_ff);
	endproperty
	a_hold_until_ready: assert property (p_hold_until_ready)
		else $error("source left before the new source was ready");

	property p_mute_gap;
		@(posedge ref_clk) disable iff (!rst_n)
		state_ff == mcc_pkg::SW_WAIT_NEW |=> !masterTick_ff;
	endproperty
	a_mute_gap: assert property (p_mute_gap)
		else $error("master tick while waiting for the new source");

	c_switch_done: cover property (@(posedge ref_clk) disable iff (!rst_n) commit);
endmodule

// file: rtl/mcc_top.sv
// master clock controller: source switch, prescalers, gating, monitor, clock output
module mcc_top (
	input  wire logic                              ref_clk,
	input  wire logic                              rst_n,
	input  wire logic [mcc_pkg::NUM_SRC-1:0]       oscLevel,
	input  wire logic [mcc_pkg::NUM_SRC-1:0]       oscReady,
	input  wire logic [mcc_pkg::ADDR_W-1:0]        regAddr,
	input  wire logic [mcc_pkg::DATA_W-1:0]        regWrData,
	input  wire logic                              regWrEn,
	input  wire logic                              regRdEn,
	output logic      [mcc_pkg::DATA_W-1:0]        regRdData,
	output logic                                   masterClkEn,
	output logic                                   cpuClkEn,
	output logic                                   memClkEn,
	output logic      [mcc_pkg::NUM_PERIPH-1:0]    periphClkEn,
	output logic                                   ckoOut,
	output logic                                   ckoOe,
	output logic                                   irq
);
	mcc_sw_if swBus ();

	// pin synchronisers and edge detection, one per source
	logic [mcc_pkg::NUM_SRC-1:0] lvlMeta_ff, lvlSync_ff, lvlLast_ff;
	logic [mcc_pkg::NUM_SRC-1:0] rdyMeta_ff, rdySync_ff;
	logic [mcc_pkg::NUM_SRC-1:0] rawTick;

	for (genvar i = 0; i < mcc_pkg::NUM_SRC; i++) begin : g_src
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				lvlMeta_ff[i] <= 1'b0;
				lvlSync_ff[i] <= 1'b0;
				lvlLast_ff[i] <= 1'b0;
				rdyMeta_ff[i] <= 1'b0;
				rdySync_ff[i] <= 1'b0;
			end else begin
				lvlMeta_ff[i] <= oscLevel[i];
				lvlSync_ff[i] <= lvlMeta_ff[i];
				lvlLast_ff[i] <= lvlSync_ff[i];
				rdyMeta_ff[i] <= oscReady[i];
				rdySync_ff[i] <= rdyMeta_ff[i];
			end
		end
		assign rawTick[i] = lvlSync_ff[i] && !lvlLast_ff[i];
	end

	// registers
	logic [mcc_pkg::SRC_W-1:0]     srcReq_ff;
	logic                          swReq_ff;
	logic [mcc_pkg::CLK_DIV_W-1:0] clkDiv_ff;
	logic [1:0]                    gate_ff;
	logic [mcc_pkg::DATA_W-1:0]    pcken1_ff, pcken2_ff;
	logic                          fcmEn_ff;
	logic [mcc_pkg::CKO_CFG_W-1:0] ckoCfg_ff;
	logic [mcc_pkg::IRQ_W-1:0]     stat_ff, mask_ff, nxt_stat;
	logic [mcc_pkg::DATA_W-1:0]    rdData_ff, rdMux;
	logic                          irq_ff;

	wire wrSrc  = regWrEn && regAddr == mcc_pkg::REG_SRC_REQ;
	wire wrDiv  = regWrEn && regAddr == mcc_pkg::REG_CLK_DIV;
	wire wrGate = regWrEn && regAddr == mcc_pkg::REG_GATE;
	wire wrPck1 = regWrEn && regAddr == mcc_pkg::REG_PCKEN1;
	wire wrPck2 = regWrEn && regAddr == mcc_pkg::REG_PCKEN2;
	wire wrFcm  = regWrEn && regAddr == mcc_pkg::REG_FCM;
	wire wrCko  = regWrEn && regAddr == mcc_pkg::REG_CKO;
	wire wrStat = regWrEn && regAddr == mcc_pkg::REG_IRQ_STAT;
	wire wrMask = regWrEn && regAddr == mcc_pkg::REG_IRQ_MASK;

	wire [mcc_pkg::FAST_DIV_W-1:0] fastDiv =
		clkDiv_ff[mcc_pkg::FAST_DIV_LSB +: mcc_pkg::FAST_DIV_W];
	wire [mcc_pkg::CPU_DIV_W-1:0]  cpuDiv  =
		clkDiv_ff[mcc_pkg::CPU_DIV_LSB +: mcc_pkg::CPU_DIV_W];

	// fast RC passes its own divider before the mux
	logic fastTick;
	mcc_divider #(.DIV_W(mcc_pkg::FAST_DIV_W)) u_fast_div (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tickIn  (rawTick[mcc_pkg::SRC_FAST_RC]),
		.divSel  (fastDiv),
		.tickOut (fastTick)
	);

	// clock failure monitor
	logic [mcc_pkg::FCM_CNT_W-1:0] monCnt_ff;
	logic                          failHeld_ff;
	wire onExt    = swBus.curSrc == mcc_pkg::SRC_HS_XTAL || swBus.curSrc == mcc_pkg::SRC_HS_USER;
	wire extTick  = rawTick[swBus.curSrc];
	wire monArmed = fcmEn_ff && onExt && !failHeld_ff;
	wire fcmFail  = monArmed && monCnt_ff == mcc_pkg::FCM_CNT_W'(mcc_pkg::FCM_TIMEOUT_CYC);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			monCnt_ff   <= '0;
			failHeld_ff <= 1'b0;
		end else begin
			if (!monArmed || extTick || fcmFail)
				monCnt_ff <= '0;
			else
				monCnt_ff <= mcc_pkg::FCM_CNT_W'(monCnt_ff + 1'b1);
			// stays held until the fallback has committed
			if (fcmFail)
				failHeld_ff <= 1'b1;
			else if (swBus.done)
				failHeld_ff <= 1'b0;
		end
	end

	assign swBus.srcTick   = {rawTick[mcc_pkg::NUM_SRC-1:1], fastTick};
	assign swBus.srcReady  = rdySync_ff;
	assign swBus.req       = swReq_ff;
	assign swBus.reqSrc    = srcReq_ff;
	assign swBus.forceFast = fcmFail;

	mcc_clk_switch u_switch (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.sw      (swBus)
	);

	// master prescaler towards core and peripherals
	logic prescTick;
	mcc_divider #(.DIV_W(mcc_pkg::CPU_DIV_W)) u_cpu_div (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tickIn  (swBus.masterTick),
		.divSel  (cpuDiv),
		.tickOut (prescTick)
	);

	// peripheral gates, register one then the two live bits of register two
	wire [mcc_pkg::NUM_PERIPH-1:0] gateVec =
		{pcken2_ff[mcc_pkg::PCKEN2_ADC], pcken2_ff[mcc_pkg::PCKEN2_WKU], pcken1_ff};
	logic [mcc_pkg::NUM_PERIPH-1:0] periph_ff;
	logic                           cpu_ff, mem_ff;

	for (genvar p = 0; p < mcc_pkg::NUM_PERIPH; p++) begin : g_periph
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n)
				periph_ff[p] <= 1'b0;
			else
				periph_ff[p] <= prescTick && gateVec[p];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_ff <= 1'b0;
			mem_ff <= 1'b0;
		end else begin
			cpu_ff <= prescTick && gate_ff[mcc_pkg::GATE_CORE];
			mem_ff <= prescTick && gate_ff[mcc_pkg::GATE_MEM];
		end
	end

	// clock output: toggles on the chosen tick, so it runs at half that rate
	wire [2:0] ckoSel = ckoCfg_ff[3:1];
	wire ckoTick = ckoSel == mcc_pkg::CKO_SEL_MASTER ? swBus.masterTick :
		ckoSel == mcc_pkg::CKO_SEL_CPU ? prescTick :
		ckoSel[2] ? 1'b0 : swBus.srcTick[ckoSel[1:0]];
	logic ckoOut_ff, ckoOe_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ckoOut_ff <= 1'b0;
			ckoOe_ff  <= 1'b0;
		end else begin
			ckoOe_ff <= ckoCfg_ff[mcc_pkg::CKO_EN];
			if (!ckoCfg_ff[mcc_pkg::CKO_EN])
				ckoOut_ff <= 1'b0;
			else if (ckoTick)
				ckoOut_ff <= !ckoOut_ff;
		end
	end

	// sticky events, set beats a write-one clear
	wire [mcc_pkg::IRQ_W-1:0] evt = {swBus.done, fcmFail};
	assign nxt_stat = (stat_ff & ~(wrStat ? regWrData[mcc_pkg::IRQ_W-1:0] : '0)) | evt;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcReq_ff <= mcc_pkg::SRC_FAST_RC;
			swReq_ff  <= 1'b0;
			clkDiv_ff <= mcc_pkg::RST_CLK_DIV;
			gate_ff   <= mcc_pkg::RST_GATE;
			pcken1_ff <= mcc_pkg::RST_PCKEN1;
			pcken2_ff <= mcc_pkg::RST_PCKEN2;
			fcmEn_ff  <= 1'b0;
			ckoCfg_ff <= '0;
			stat_ff   <= '0;
			mask_ff   <= '0;
			irq_ff    <= 1'b0;
		end else begin
			swReq_ff <= wrSrc;
			if (wrSrc)
				srcReq_ff <= regWrData[mcc_pkg::SRC_W-1:0];
			// fallback forces the fast RC divider back to eight
			if (fcmFail)
				clkDiv_ff[mcc_pkg::FAST_DIV_LSB +: mcc_pkg::FAST_DIV_W] <= mcc_pkg::FAST_DIV_8;
			else if (wrDiv)
				clkDiv_ff <= regWrData[mcc_pkg::CLK_DIV_W-1:0];
			if (wrGate)
				gate_ff <= regWrData[1:0];
			if (wrPck1)
				pcken1_ff <= regWrData;
			if (wrPck2)
				pcken2_ff <= regWrData & mcc_pkg::PCKEN2_MASK;
			if (wrFcm)
				fcmEn_ff <= regWrData[0];
			if (wrCko)
				ckoCfg_ff <= regWrData[mcc_pkg::CKO_CFG_W-1:0];
			if (wrMask)
				mask_ff <= regWrData[mcc_pkg::IRQ_W-1:0];
			stat_ff <= nxt_stat;
			irq_ff  <= |(nxt_stat & (wrMask ? regWrData[mcc_pkg::IRQ_W-1:0] : mask_ff));
		end
	end

	always_comb begin
		if (regAddr == mcc_pkg::REG_SRC_REQ)
			rdMux = {6'h00, srcReq_ff};
		else if (regAddr == mcc_pkg::REG_SW_STAT)
			rdMux = {rdySync_ff, 1'b0, swBus.curSrc, swBus.busy};
		else if (regAddr == mcc_pkg::REG_CLK_DIV)
			rdMux = {3'h0, clkDiv_ff};
		else if (regAddr == mcc_pkg::REG_GATE)
			rdMux = {6'h00, gate_ff};
		else if (regAddr == mcc_pkg::REG_PCKEN1)
			rdMux = pcken1_ff;
		else if (regAddr == mcc_pkg::REG_PCKEN2)
			rdMux = pcken2_ff;
		else if (regAddr == mcc_pkg::REG_FCM)
			rdMux = {7'h00, fcmEn_ff};
		else if (regAddr == mcc_pkg::REG_CKO)
			rdMux = {4'h0, ckoCfg_ff};
		else if (regAddr == mcc_pkg::REG_IRQ_STAT)
			rdMux = {6'h00, stat_ff};
		else if (regAddr == mcc_pkg::REG_IRQ_MASK)
			rdMux = {6'h00, mask_ff};
		else
			rdMux = '0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdData_ff <= '0;
		else
			rdData_ff <= regRdEn ? rdMux : '0;
	end

	assign regRdData   = rdData_ff;
	assign masterClkEn = swBus.masterTick;
	assign cpuClkEn    = cpu_ff;
	assign memClkEn    = mem_ff;
	assign periphClkEn = periph_ff;
	assign ckoOut      = ckoOut_ff;
	assign ckoOe       = ckoOe_ff;
	assign irq         = irq_ff;

	property p_presc_chain;
		@(posedge ref_clk) disable iff (!rst_n)
		cpu_ff |-> $past(swBus.masterTick, 2) && $past(gate_ff[mcc_pkg::GATE_CORE]);
	endproperty
	a_presc_chain: assert property (p_presc_chain)
		else $error("core tick without master tick two cycles earlier");

	property p_periph_gate;
		@(posedge ref_clk) disable iff (!rst_n)
		(periph_ff & ~$past(gateVec)) == '0;
	endproperty
	a_periph_gate: assert property (p_periph_gate)
		else $error("peripheral tick while its gate is off");

	property p_mem_gate;
		@(posedge ref_clk) disable iff (!rst_n)
		!gate_ff[mcc_pkg::GATE_MEM] ##1 !gate_ff[mcc_pkg::GATE_MEM] |-> !mem_ff;
	endproperty
	a_mem_gate: assert property (p_mem_gate)
		else $error("memory tick while memory gate is off");

	property p_monitor_off;
		@(posedge ref_clk) disable iff (!rst_n)
		!fcmEn_ff |-> !fcmFail ##1 (monCnt_ff == '0);
	endproperty
	a_monitor_off: assert property (p_monitor_off)
		else $error("failure monitor active while disabled");

	property p_fallback;
		@(posedge ref_clk) disable iff (!rst_n)
		fcmFail |=> swBus.busy && stat_ff[mcc_pkg::IRQ_FCM] && fastDiv == mcc_pkg::FAST_DIV_8;
	endproperty
	a_fallback: assert property (p_fallback)
		else $error("failure did not start the fallback to fast RC over eight");

	property p_irq_level;
		@(posedge ref_clk) disable iff (!rst_n)
		irq_ff == |(stat_ff & mask_ff);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level disagrees with status and mask");

	property p_busy_flag;
		@(posedge ref_clk) disable iff (!rst_n)
		(swReq_ff && srcReq_ff != swBus.curSrc && !swBus.busy) |=> swBus.busy;
	endproperty
	a_busy_flag: assert property (p_busy_flag)
		else $error("pending switch not flagged");

	property p_cko_off;
		@(posedge ref_clk) disable iff (!rst_n)
		!ckoCfg_ff[mcc_pkg::CKO_EN] |=> !ckoOut_ff && !ckoOe_ff;
	endproperty
	a_cko_off: assert property (p_cko_off)
		else $error("clock output active while disabled");

	property p_read_slot;
		@(posedge ref_clk) disable iff (!rst_n)
		!regRdEn |=> rdData_ff == '0;
	endproperty
	a_read_slot: assert property (p_read_slot)
		else $error("read data outside its slot");

	c_fcm_fail: cover property (@(posedge ref_clk) disable iff (!rst_n) fcmFail);
	c_cko_run: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(ckoOut_ff));
	c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_ff));
endmodule

// file: tb/mcc_osc_model.sv
// oscillator pins feeding the master clock controller
module mcc_osc_model (
	input  wire logic       stopXtal,
	input  wire logic [3:0] readyMask,
	output logic      [3:0] oscLevel,
	output logic      [3:0] oscReady
);
	timeunit 1ns;
	timeprecision 1ps;
	// four free-running sources, rates kept below the sampling limit
	initial begin
		oscLevel = 4'h0;
		#1; // edges kept clear of the sampling edge
		fork
			forever #50 oscLevel[0] = ~oscLevel[0];
			forever #400 oscLevel[1] = ~oscLevel[1];
			// a failed crystal stands still at its last level
			forever #60 oscLevel[2] = oscLevel[2] ^ !stopXtal;
			forever #70 oscLevel[3] = ~oscLevel[3];
		join
	end
	// ready withheld by the bench to stall a switch
	assign oscReady = readyMask;
endmodule

// file: tb/master_clock_controller_test.sv
// self-checking bench of the master clock controller
module master_clock_controller_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rst_n, regWrEn, regRdEn, stopXtal;
	logic [7:0]  regAddr, regWrData, regRdData, rd;
	logic [3:0]  oscLevel, oscReady, readyMask;
	logic        masterClkEn, cpuClkEn, memClkEn, ckoOut, ckoOe, irq;
	logic [9:0]  periphClkEn;
	logic [11:0] seen;
	logic [15:0] rstTab [10] = '{16'h0000, 16'h0218, 16'h0303, 16'h04FF, 16'h050C,
		16'h0600, 16'h0700, 16'h0800, 16'h0900, 16'h0A00};
	// output select: master, prescaled, fast RC
	logic [7:0]  coSel [3] = '{8'h09, 8'h0B, 8'h01};
	int          num_errors, n_tests, cnt, cpuCnt, ckoCnt, seed, v;

	mcc_osc_model osc_u (.stopXtal(stopXtal), .readyMask(readyMask), .oscLevel(oscLevel),
		.oscReady(oscReady));
	mcc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .oscLevel(oscLevel), .oscReady(oscReady),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .masterClkEn(masterClkEn), .cpuClkEn(cpuClkEn),
		.memClkEn(memClkEn), .periphClkEn(periphClkEn), .ckoOut(ckoOut), .ckoOe(ckoOe),
		.irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// expected enables: {memory, core, converter, wakeup, gate one}
	function automatic logic [11:0] exp_en(input int x);
		return {x[17], x[16], x[11], x[10], x[7:0]};
	endfunction
	// strobes dropped then one idle edge, so no signal is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		@(negedge ref_clk);
		rd = regRdData;
		@(posedge ref_clk);
	endtask
	task automatic watch(input int n);
		seen = 12'h000;
		cnt = 0;
		cpuCnt = 0;
		ckoCnt = 0;
		repeat (n) begin
			@(negedge ref_clk);
			seen |= {memClkEn, cpuClkEn, periphClkEn};
			cnt += masterClkEn;
			cpuCnt += cpuClkEn;
			ckoCnt += ckoOut;
		end
		@(posedge ref_clk);
	endtask
	task automatic wait_idle;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 200; i++) begin
			rdr(mcc_pkg::REG_SW_STAT);
			if (rd[0] === 1'b0) return;
		end
		num_errors++;
		final_report();
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		{rst_n, regWrEn, regRdEn, stopXtal} = 4'h0;
		{regAddr, regWrData} = 16'h0000;
		readyMask = 4'hD;
		num_errors = 0;
		n_tests = 0;
		seed = 32'hdc36;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (rstTab[i]) begin
			rdr(rstTab[i][15:8]);
			chk_reg("reset value", rstTab[i][7:0], rd);
		end
		watch(400);
		chk_pin("master ticks", 12'h001, 12'(cnt >= 9 && cnt <= 11));
		chk_pin("all enables", 12'hFFF, seen);
		$display("reset test done");
		wr(mcc_pkg::REG_CLK_DIV, 8'h12);
		watch(400);
		chk_pin("master over four", 12'h001, 12'(cnt >= 19 && cnt <= 21));
		chk_pin("core ticks over four", 12'h001, 12'(cpuCnt >= 4 && cpuCnt <= 6));
		wr(mcc_pkg::REG_CLK_DIV, 8'h18);
		$display("prescaler test done");
		// corners first: all stopped, all running, then random masks
		for (int k = 0; k < 5; k++) begin
			v = (k == 0) ? 0 : (k == 1) ? -1 : $random(seed);
			wr(mcc_pkg::REG_PCKEN1, v[7:0]);
			wr(mcc_pkg::REG_PCKEN2, v[15:8]);
			wr(mcc_pkg::REG_GATE, {6'h00, v[17:16]});
			rdr(mcc_pkg::REG_PCKEN2);
			chk_reg("gate two", v[15:8] & 8'h0C, rd);
			watch(200);
			chk_pin("clock enables", exp_en(v), seen);
		end
		wr(mcc_pkg::REG_GATE, 8'h03);
		$display("gating test done");
		wr(mcc_pkg::REG_SRC_REQ, 8'h01);
		repeat (3) @(posedge ref_clk);
		rdr(mcc_pkg::REG_SW_STAT);
		chk_reg("pending switch", 8'hD1, rd);
		watch(400);
		chk_pin("old source kept", 12'h001, 12'(cnt >= 9));
		readyMask <= 4'hF;
		wait_idle();
		rdr(mcc_pkg::REG_SW_STAT);
		chk_reg("switched", 8'hF2, rd);
		rdr(mcc_pkg::REG_IRQ_STAT);
		chk_reg("switch done", 8'h02, rd);
		chk_pin("masked irq", 12'h000, 12'(irq));
		wr(mcc_pkg::REG_IRQ_MASK, 8'h02);
		watch(2);
		chk_pin("irq set", 12'h001, 12'(irq));
		wr(mcc_pkg::REG_IRQ_STAT, 8'h02);
		watch(2);
		chk_pin("irq cleared", 12'h000, 12'(irq));
		$display("switch test done");
		wr(mcc_pkg::REG_SRC_REQ, 8'h02);
		wait_idle();
		rdr(mcc_pkg::REG_SW_STAT);
		chk_reg("crystal", 8'hF4, rd);
		stopXtal <= 1'b1;
		watch(150);
		rdr(mcc_pkg::REG_IRQ_STAT);
		chk_reg("monitor off", 8'h02, rd);
		wr(mcc_pkg::REG_IRQ_MASK, 8'h01);
		wr(mcc_pkg::REG_FCM, 8'h01);
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge ref_clk);
		chk_pin("failure irq", 12'h001, 12'(irq));
		if (irq !== 1'b1) final_report();
		wait_idle();
		rdr(mcc_pkg::REG_SW_STAT);
		chk_reg("fallback", 8'hF0, rd);
		watch(400);
		chk_pin("fallback rate", 12'h001, 12'(cnt >= 9 && cnt <= 11));
		$display("monitor test done");
		foreach (coSel[i]) begin
			wr(mcc_pkg::REG_CKO, coSel[i]);
			watch(100);
			chk_pin("clock output", 12'h001, 12'(ckoOe && ckoCnt > 0));
		end
		wr(mcc_pkg::REG_CKO, 8'h00);
		watch(20);
		chk_pin("output off", 12'h000, {10'h000, ckoOe, 1'(ckoCnt > 0)});
		$display("clock output test done");
		final_report();
	end
endmodule
